// ---- logic/position_serializer_pkg.sv ----
// Constants shared by the position serializer design files
package position_serializer_pkg;

  // Position word layout
  localparam int COARSE_BITS = 11;
  localparam int FINE_BITS = 4;
  localparam int CODE_BITS = 12;
  localparam int WORD_BITS = 16;
  localparam int STEPS_PER_REV = 4096;

  // Clock and speed limits
  localparam longint CLK_HZ = 100000000;
  localparam longint FINE_LIMIT_RPM = 1000;
  localparam longint CODE_LIMIT_RPM = 12000;
  localparam longint SHIFT_CLK_MAX_HZ = 16000000;
  // Least time between two 12-bit steps, rounded up to whole cycles
  localparam longint FINE_MIN_CYCLES_L =
    (CLK_HZ * 60 + FINE_LIMIT_RPM * STEPS_PER_REV - 1) / (FINE_LIMIT_RPM * STEPS_PER_REV);
  localparam longint CODE_MIN_CYCLES_L =
    (CLK_HZ * 60 + CODE_LIMIT_RPM * STEPS_PER_REV - 1) / (CODE_LIMIT_RPM * STEPS_PER_REV);
  localparam int GAP_W = 12;
  localparam logic [GAP_W-1:0] FINE_MIN_CYCLES = GAP_W'(FINE_MIN_CYCLES_L);
  localparam logic [GAP_W-1:0] CODE_MIN_CYCLES = GAP_W'(CODE_MIN_CYCLES_L);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_POSITION = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_PINS = 8'h10;

  // Control fields
  localparam int CTRL_FREEZE = 0;
  localparam logic [0:0] CTRL_RESET = 1'h0;

  // Status and mask fields
  localparam int EV_BITS = 3;
  localparam int EV_LIGHT_ERROR = 0;
  localparam int EV_FINE_OVERSPEED = 1;
  localparam int EV_CODE_JUMP = 2;
  localparam logic [EV_BITS-1:0] STATUS_RESET = 3'h0;
  localparam logic [EV_BITS-1:0] MASK_RESET = 3'h0;

  // Pin status fields
  localparam int PIN_CORR_EN = 0;
  localparam int PIN_TOP_INV = 1;
  localparam int PIN_LOAD_SEL = 2;
  localparam int PIN_LIGHT_ERR = 3;
  localparam int PIN_SINE = 4;
  localparam int PIN_COSINE = 5;
  localparam int PIN_FINE_VALID = 6;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Shift register mode
  typedef enum logic [1:0] {
    MODE_LOAD = 2'b01,
    MODE_SHIFT = 2'b10
  } shift_mode_t;

endpackage

// ---- logic/pin_synchronizer.sv ----
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_synchronizer #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

// ---- logic/gray_code_position_serializer.sv ----
// Gray position word builder, serial shift register, light alarm and AXI4-Lite registers
//
// Overview of operation
// - Word is 12 Gray bits plus four fine bits
// - Fine bits trusted only up to 1000 RPM
// - Upper twelve bits stay monotone to 12000 RPM
// - Correction aligns coarse edges to sine/cosine
// - Correction touches only upper twelve bits
// - Correction enable pin: 1 on, 0 off
// - Serial output sends top bit first
// - Invert pin flips the top code bit
// - Invert active at 1, plain at 0
// - Cascade input enters far register end
// - Select pin: 1 load, 0 shift
// - Load mode outputs captured top bit
// - Each shift clock presents next bit
// - Shift clock up to 16 MHz
// - Light error raised on LED regulation limit
// - Sine/cosine digitized, used as references
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gray_code_position_serializer
  import position_serializer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [COARSE_BITS-1:0] I_COARSE_TRACK_BITS,
  input wire logic I_SINE_DIGITAL_BIT,
  input wire logic I_COSINE_DIGITAL_BIT,
  input wire logic [FINE_BITS-1:0] I_INTERPOLATED_FINE_BITS,
  input wire logic I_GRAY_CORRECTION_ENABLE,
  input wire logic I_TOP_BIT_INVERT,
  input wire logic I_LOAD_SHIFT_SELECT,
  input wire logic I_SHIFT_CLOCK,
  input wire logic I_CASCADE_IN,
  input wire logic I_LED_LIMIT_EXCEEDED,
  output logic O_SERIAL_DATA,
  output logic O_LIGHT_ERROR_FLAG,
  output logic O_SINE_DIGITAL_BIT,
  output logic O_COSINE_DIGITAL_BIT,
  output logic O_IRQ,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY
);

  function automatic logic [CODE_BITS-1:0] gray_to_bin(input logic [CODE_BITS-1:0] g);
    logic [CODE_BITS-1:0] b;
    b = '0;
    b[CODE_BITS-1] = g[CODE_BITS-1];
    for (int i = CODE_BITS - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [CODE_BITS-1:0] bin_to_gray(input logic [CODE_BITS-1:0] b);
    return b ^ (b >> 1);
  endfunction

  localparam int SYNC_W = COARSE_BITS + FINE_BITS + 8;

  // Every pin crosses two flip-flops before use
  logic [SYNC_W-1:0] pins_sync;
  pin_synchronizer #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_async({I_COARSE_TRACK_BITS, I_INTERPOLATED_FINE_BITS, I_SINE_DIGITAL_BIT, I_COSINE_DIGITAL_BIT,
              I_GRAY_CORRECTION_ENABLE, I_TOP_BIT_INVERT, I_LOAD_SHIFT_SELECT, I_SHIFT_CLOCK,
              I_CASCADE_IN, I_LED_LIMIT_EXCEEDED}),
    .o_sync(pins_sync)
  );

  wire [COARSE_BITS-1:0] coarse = pins_sync[SYNC_W-1 -: COARSE_BITS];
  wire [FINE_BITS-1:0] fine = pins_sync[FINE_BITS+7 -: FINE_BITS];
  wire sine = pins_sync[7];
  wire cosine = pins_sync[6];
  wire corr_en = pins_sync[5];
  wire top_inv = pins_sync[4];
  wire load_sel = pins_sync[3];
  wire shift_clk = pins_sync[2];
  wire cascade = pins_sync[1];
  wire led_limit = pins_sync[0];

  // Position word assembly
  logic ctrl_freeze;
  logic [WORD_BITS-1:0] pos_word;

  // Coarse binary from the eleven track bits alone; its lsb should equal cosine
  wire [CODE_BITS-1:0] coarse_bin_full = gray_to_bin({coarse, 1'b0});
  wire [COARSE_BITS-1:0] coarse_bin = coarse_bin_full[CODE_BITS-1:1];
  wire quarter_lsb = sine ^ cosine;
  wire coarse_mismatch = coarse_bin[0] ^ cosine;
  // Just after a cosine edge the coarse track lags, just before it leads
  wire [COARSE_BITS-1:0] coarse_fixed = !coarse_mismatch ? coarse_bin :
                                        quarter_lsb ? COARSE_BITS'(coarse_bin - 1'b1) :
                                        COARSE_BITS'(coarse_bin + 1'b1);
  wire [CODE_BITS-1:0] corrected_gray = bin_to_gray({coarse_fixed, quarter_lsb});
  wire [CODE_BITS-1:0] raw_gray = {coarse, sine};
  wire [CODE_BITS-1:0] code_gray = corr_en ? corrected_gray : raw_gray;
  wire [CODE_BITS-1:0] out_gray = {code_gray[CODE_BITS-1] ^ top_inv, code_gray[CODE_BITS-2:0]};
  // Fine bits bypass the correction path untouched
  wire [WORD_BITS-1:0] next_pos_word = {out_gray, fine};

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pos_word <= '0;
    end else if (!ctrl_freeze) begin
      pos_word <= next_pos_word;
    end
  end

  // Speed and monotonicity monitor on the 12-bit code
  logic [CODE_BITS-1:0] prev_bin;
  logic [GAP_W-1:0] step_gap;
  logic fine_valid;
  logic monitor_armed;
  wire [CODE_BITS-1:0] code_bin = gray_to_bin(code_gray);
  wire [CODE_BITS-1:0] code_delta = CODE_BITS'(code_bin - prev_bin);
  wire code_moved = monitor_armed && (code_bin != prev_bin);
  wire single_step = (code_delta == CODE_BITS'(1)) || (code_delta == {CODE_BITS{1'b1}});
  wire too_fast_fine = code_moved && (step_gap < FINE_MIN_CYCLES);
  // A skip of more than one step, or steps closer than the 12000 RPM pace
  wire code_jump = code_moved && (!single_step || step_gap < CODE_MIN_CYCLES);

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      prev_bin <= '0;
      step_gap <= '0;
      fine_valid <= 1'b0;
      monitor_armed <= 1'b0;
    end else begin
      monitor_armed <= 1'b1;
      prev_bin <= code_bin;
      if (code_moved) begin
        step_gap <= '0;
        fine_valid <= !too_fast_fine;
      end else if (step_gap != {GAP_W{1'b1}}) begin
        step_gap <= GAP_W'(step_gap + 1'b1);
      end
    end
  end

  // Serial shift register, stepped by the sampled shift clock
  logic shift_clk_d;
  logic [WORD_BITS-1:0] shreg;
  shift_mode_t mode;
  // Edge seen about three cycles after the pin; fine at 16 MHz with a 100 MHz clock
  wire shift_rise = shift_clk && !shift_clk_d;
  shift_mode_t next_mode;
  assign next_mode = load_sel ? MODE_LOAD : MODE_SHIFT;
  logic [WORD_BITS-1:0] next_shreg;

  always_comb begin
    next_shreg = shreg;
    case (mode)
      MODE_LOAD: next_shreg = pos_word;
      MODE_SHIFT: begin
        if (shift_rise) begin
          next_shreg = {shreg[WORD_BITS-2:0], cascade};
        end
      end
      default: next_shreg = pos_word;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      shift_clk_d <= 1'b0;
      mode <= MODE_LOAD;
      shreg <= '0;
      O_SERIAL_DATA <= 1'b0;
    end else begin
      shift_clk_d <= shift_clk;
      mode <= next_mode;
      shreg <= next_shreg;
      // Settles right after the rising edge, so it holds while the clock is low
      O_SERIAL_DATA <= next_shreg[WORD_BITS-1];
    end
  end

  // Pin outputs
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_LIGHT_ERROR_FLAG <= 1'b0;
      O_SINE_DIGITAL_BIT <= 1'b0;
      O_COSINE_DIGITAL_BIT <= 1'b0;
    end else begin
      O_LIGHT_ERROR_FLAG <= led_limit;
      O_SINE_DIGITAL_BIT <= sine;
      O_COSINE_DIGITAL_BIT <= cosine;
    end
  end

  // Events and interrupt
  logic light_d;
  logic [EV_BITS-1:0] status;
  logic [EV_BITS-1:0] mask;
  logic [EV_BITS-1:0] events;
  logic [EV_BITS-1:0] status_clear;

  always_comb begin
    events = '0;
    events[EV_LIGHT_ERROR] = led_limit && !light_d;
    events[EV_FINE_OVERSPEED] = too_fast_fine;
    events[EV_CODE_JUMP] = code_jump;
  end

  wire [EV_BITS-1:0] next_status = (status & ~status_clear) | events;

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      light_d <= 1'b0;
      status <= STATUS_RESET;
      O_IRQ <= 1'b0;
    end else begin
      light_d <= led_limit;
      // A new event wins over a clear in the same cycle
      status <= next_status;
      O_IRQ <= |(next_status & mask);
    end
  end

  // AXI4-Lite write channel
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = I_AWVALID && O_AWREADY;
  wire w_take = I_WVALID && O_WREADY;
  wire wr_fire = !O_AWREADY && !O_WREADY && !O_BVALID;
  wire [7:0] wr_ofs = 8'(aw_addr);
  wire wr_hit_ctrl = wr_ofs == OFS_CTRL;
  wire wr_hit_status = wr_ofs == OFS_STATUS;
  wire wr_hit_mask = wr_ofs == OFS_MASK;
  wire wr_ro = (wr_ofs == OFS_POSITION) || (wr_ofs == OFS_PINS);
  wire wr_known = wr_hit_ctrl || wr_hit_status || wr_hit_mask || wr_ro;

  always_comb begin
    status_clear = '0;
    if (wr_fire && wr_hit_status && w_strb[0]) begin
      status_clear = w_data[EV_BITS-1:0];
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (aw_take) begin
        aw_addr <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (w_take) begin
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        O_BVALID <= 1'b1;
        O_BRESP <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl_freeze <= CTRL_RESET;
      mask <= MASK_RESET;
    end else if (wr_fire && w_strb[0]) begin
      if (wr_hit_ctrl) begin
        ctrl_freeze <= w_data[CTRL_FREEZE];
      end
      if (wr_hit_mask) begin
        mask <= w_data[EV_BITS-1:0];
      end
    end
  end

  // AXI4-Lite read channel
  logic [31:0] pin_word;
  always_comb begin
    pin_word = '0;
    pin_word[PIN_CORR_EN] = corr_en;
    pin_word[PIN_TOP_INV] = top_inv;
    pin_word[PIN_LOAD_SEL] = load_sel;
    pin_word[PIN_LIGHT_ERR] = led_limit;
    pin_word[PIN_SINE] = sine;
    pin_word[PIN_COSINE] = cosine;
    pin_word[PIN_FINE_VALID] = fine_valid;
  end

  wire [7:0] rd_ofs = 8'(I_ARADDR);
  wire rd_hit_ctrl = rd_ofs == OFS_CTRL;
  wire rd_hit_pos = rd_ofs == OFS_POSITION;
  wire rd_hit_status = rd_ofs == OFS_STATUS;
  wire rd_hit_mask = rd_ofs == OFS_MASK;
  wire rd_hit_pins = rd_ofs == OFS_PINS;
  wire rd_known = rd_hit_ctrl || rd_hit_pos || rd_hit_status || rd_hit_mask || rd_hit_pins;
  wire [31:0] rd_value = rd_hit_ctrl ? 32'(ctrl_freeze) :
                         rd_hit_pos ? 32'(pos_word) :
                         rd_hit_status ? 32'(status) :
                         rd_hit_mask ? 32'(mask) :
                         rd_hit_pins ? pin_word : 32'h0;
  wire ar_take = I_ARVALID && O_ARREADY;

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= '0;
      O_RRESP <= RESP_OKAY;
    end else if (ar_take) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= rd_value;
      O_RRESP <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

endmodule

// ---- test/serializer_checker_asserts.sv ----
// Port-level assertions for the position serializer
`timescale 1ns/1ps
module serializer_checker
  import position_serializer_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_LED_LIMIT_EXCEEDED,
  input wire logic O_LIGHT_ERROR_FLAG,
  input wire logic I_SINE_DIGITAL_BIT,
  input wire logic O_SINE_DIGITAL_BIT,
  input wire logic I_COSINE_DIGITAL_BIT,
  input wire logic O_COSINE_DIGITAL_BIT,
  input wire logic [COARSE_BITS-1:0] I_COARSE_TRACK_BITS,
  input wire logic I_TOP_BIT_INVERT,
  input wire logic I_GRAY_CORRECTION_ENABLE,
  input wire logic I_LOAD_SHIFT_SELECT,
  input wire logic I_SHIFT_CLOCK,
  input wire logic O_SERIAL_DATA,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic I_RREADY
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  wire top_expect = I_COARSE_TRACK_BITS[COARSE_BITS-1] ^ I_TOP_BIT_INVERT;

  // Long enough to cover pin sync, mode sync and word reload
  // Correction may carry into the top bit, so only the plain code is compared
  sequence load_steady;
    (I_LOAD_SHIFT_SELECT && !I_GRAY_CORRECTION_ENABLE && $stable(I_COARSE_TRACK_BITS[COARSE_BITS-1]) &&
     $stable(I_TOP_BIT_INVERT)) [*8];
  endsequence
  sequence shift_idle;
    (!I_LOAD_SHIFT_SELECT && !I_SHIFT_CLOCK) [*6];
  endsequence

  chk_light_set: assert property (I_LED_LIMIT_EXCEEDED [*6] |-> O_LIGHT_ERROR_FLAG)
    else $error("light flag not raised");
  chk_light_clear: assert property (!I_LED_LIMIT_EXCEEDED [*6] |-> !O_LIGHT_ERROR_FLAG)
    else $error("light flag not cleared");
  chk_sine_copy: assert property (I_SINE_DIGITAL_BIT [*5] |-> O_SINE_DIGITAL_BIT)
    else $error("sine output wrong");
  chk_cosine_copy: assert property (!I_COSINE_DIGITAL_BIT [*5] |-> !O_COSINE_DIGITAL_BIT)
    else $error("cosine output wrong");
  chk_load_top: assert property (load_steady |-> O_SERIAL_DATA == top_expect)
    else $error("load mode output not top bit");
  chk_shift_hold: assert property (shift_idle |-> $stable(O_SERIAL_DATA))
    else $error("serial output moved without shift edge");
  chk_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  chk_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
endmodule

bind gray_code_position_serializer serializer_checker u_chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_LED_LIMIT_EXCEEDED(I_LED_LIMIT_EXCEEDED), .O_LIGHT_ERROR_FLAG(O_LIGHT_ERROR_FLAG),
  .I_SINE_DIGITAL_BIT(I_SINE_DIGITAL_BIT), .O_SINE_DIGITAL_BIT(O_SINE_DIGITAL_BIT),
  .I_COSINE_DIGITAL_BIT(I_COSINE_DIGITAL_BIT), .O_COSINE_DIGITAL_BIT(O_COSINE_DIGITAL_BIT),
  .I_COARSE_TRACK_BITS(I_COARSE_TRACK_BITS), .I_TOP_BIT_INVERT(I_TOP_BIT_INVERT),
  .I_GRAY_CORRECTION_ENABLE(I_GRAY_CORRECTION_ENABLE),
  .I_LOAD_SHIFT_SELECT(I_LOAD_SHIFT_SELECT), .I_SHIFT_CLOCK(I_SHIFT_CLOCK), .O_SERIAL_DATA(O_SERIAL_DATA),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .I_RREADY(I_RREADY));

// ---- test/serial_host_model.sv ----
// Host controller that loads and clocks out the serial position word
`timescale 1ns/1ps
module serial_host_model (
  input wire logic i_clk,
  input wire logic i_serial_data,
  output logic o_shift_clock,
  output logic o_load_select
);
  initial begin
    o_shift_clock = 1'b0;
    o_load_select = 1'b1;
  end

  // Clock stands low between frames
  task automatic read_bits(input int n, output logic [31:0] bits);
    bits = '0;
    o_load_select <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_load_select <= 1'b0;
    repeat (8) @(posedge i_clk);
    for (int k = 0; k < n; k++) begin
      bits = {bits[30:0], i_serial_data}; // Late in the low phase
      o_shift_clock <= 1'b1; // 80 ns period
      repeat (4) @(posedge i_clk);
      o_shift_clock <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    o_load_select <= 1'b1;
  endtask
endmodule

// ---- test/gray_code_position_serializer_tb.sv ----
// Self-checking bench for the position serializer
`timescale 1ns/1ps
module gray_code_position_serializer_tb;
  import position_serializer_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [10:0] coarse = '0;
  logic [3:0] fine = '0;
  logic sin = 1'b0, cos = 1'b0, corr = 1'b0, inv = 1'b0, cas = 1'b0, led = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic sck, sel, ser, light_error_flag, sin_o, cos_o, irq, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d, b;
  logic [1:0] r;
  int miscompares = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  gray_code_position_serializer dut (.I_CLK(clk), .I_SYS_RST(rst), .I_COARSE_TRACK_BITS(coarse),
    .I_SINE_DIGITAL_BIT(sin), .I_COSINE_DIGITAL_BIT(cos), .I_INTERPOLATED_FINE_BITS(fine),
    .I_GRAY_CORRECTION_ENABLE(corr), .I_TOP_BIT_INVERT(inv), .I_LOAD_SHIFT_SELECT(sel),
    .I_SHIFT_CLOCK(sck), .I_CASCADE_IN(cas), .I_LED_LIMIT_EXCEEDED(led), .O_SERIAL_DATA(ser),
    .O_LIGHT_ERROR_FLAG(light_error_flag), .O_SINE_DIGITAL_BIT(sin_o), .O_COSINE_DIGITAL_BIT(cos_o), .O_IRQ(irq),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready));

  serial_host_model host (.i_clk(clk), .i_serial_data(ser), .o_shift_clock(sck), .o_load_select(sel));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Handshake state is sampled at negedge, where registered outputs are settled
  task axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic aw_hit, w_hit, done;
    done = 1'b0;
    awaddr <= a;
    wdata <= wd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      done = bvalid;
      rs = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  // Ready is raised late on purpose so read data must stand
  task axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic ar_hit, rv, done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ar_hit = arvalid && arready;
      rv = rvalid;
      done = rvalid && rready;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
      rready <= rv && !done;
    end
  endtask

  task t_regs;
    axi_rd(OFS_CTRL, d, r);
    check("ctrl reset", d, 32'h0);
    axi_rd(OFS_STATUS, d, r);
    check("status reset", d, 32'h0);
    axi_rd(OFS_MASK, d, r);
    check("mask reset", d, 32'h0);
    axi_rd(8'h20, d, r);
    check("unmapped rresp", 32'(r), 32'(RESP_SLVERR));
    axi_wr(8'h24, 32'h1, r);
    check("unmapped bresp", 32'(r), 32'(RESP_SLVERR));
    $display("test regs done");
  endtask

  task do_word(input logic iv, input logic cv, input logic [10:0] co, input logic s, input logic k,
               input logic [3:0] f, input logic [15:0] exp);
    inv <= iv;
    corr <= cv;
    coarse <= co;
    sin <= s;
    cos <= k;
    fine <= f;
    repeat (8) @(posedge clk);
    axi_rd(OFS_POSITION, d, r);
    check("position word", d, {16'h0000, exp});
  endtask

  task t_word;
    do_word(1'b0, 1'b0, 11'h400, 1'b1, 1'b0, 4'h9, 16'h8019);
    do_word(1'b1, 1'b0, 11'h400, 1'b1, 1'b0, 4'h9, 16'h0019);
    do_word(1'b0, 1'b1, 11'h000, 1'b1, 1'b1, 4'ha, 16'h003a);
    do_word(1'b0, 1'b0, 11'h000, 1'b1, 1'b1, 4'ha, 16'h001a);
    do_word(1'b0, 1'b1, 11'h001, 1'b1, 1'b0, 4'h5, 16'h0015);
    // Two moves so far were multi-step jumps and one a single step, all far faster than either limit
    axi_rd(OFS_STATUS, d, r);
    check("jump events", d, 32'h6);
    axi_rd(OFS_PINS, d, r);
    check("pin word", d, 32'h15);
    axi_wr(OFS_CTRL, 32'h1, r);
    fine <= 4'h6;
    repeat (8) @(posedge clk);
    axi_rd(OFS_POSITION, d, r);
    check("frozen word", d, 32'h15);
    axi_wr(OFS_CTRL, 32'h0, r);
    $display("test word done");
  endtask

  task t_serial;
    do_word(1'b0, 1'b0, 11'h555, 1'b0, 1'b0, 4'h0, 16'haaa0);
    cas <= 1'b1;
    host.read_bits(18, b);
    check("serial word", 32'(b[17:2]), 32'h0000aaa0);
    check("cascade bits", 32'(b[1:0]), 32'h3);
    // Top bit forced low so the leftover cascade ones cannot pass
    inv <= 1'b1;
    repeat (8) @(posedge clk);
    check("load mode bit", 32'(ser), 32'h0);
    $display("test serial done");
  endtask

  task t_irq;
    led <= 1'b1;
    sin <= 1'b1;
    cos <= 1'b0;
    axi_wr(OFS_MASK, 32'h1, r);
    repeat (6) @(posedge clk);
    check("light flag", 32'(light_error_flag), 32'h1);
    check("irq set", 32'(irq), 32'h1);
    check("quadrature copy", 32'({sin_o, cos_o}), 32'h2);
    axi_rd(OFS_STATUS, d, r);
    check("light event", 32'(d[EV_LIGHT_ERROR]), 32'h1);
    axi_wr(OFS_MASK, 32'h0, r);
    repeat (3) @(posedge clk);
    check("irq masked", 32'(irq), 32'h0);
    axi_wr(OFS_MASK, 32'h1, r);
    repeat (3) @(posedge clk);
    check("irq unmasked", 32'(irq), 32'h1);
    led <= 1'b0;
    repeat (6) @(posedge clk);
    check("light flag off", 32'(light_error_flag), 32'h0);
    axi_wr(OFS_STATUS, 32'h1, r);
    repeat (3) @(posedge clk);
    check("irq cleared", 32'(irq), 32'h0);
    axi_rd(OFS_STATUS, d, r);
    check("light event cleared", 32'(d[EV_LIGHT_ERROR]), 32'h0);
    $display("test irq done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_word();
    t_serial();
    t_irq();
    end_sim();
  end

  // Whole run is a few hundred cycles
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule
